// File: verilog/pdi_defs.vh
// Overview of operation
// - Enable bit one passes interrupt, zero blocks.
// - Reserved enable and bank-one bits read zero.
// - Enable and direction registers clear on reset.
// - Direction one drives the drive-value bit.
// - Direction zero leaves the pin as input.
// - Input pullup on when drive-value bit one.
// - Each pin has its own direction bit.
// - Bank-one bit six resets unless disabled.
// - Low on that pin resets, even self-driven.
// - Level registers return current pin state.
// - Flags interrupt when enabled, held until cleared.
`ifndef PDI_DEFS_VH
`define PDI_DEFS_VH

// Register indices; the byte address is four times the index.
`define PDI_IDX_LINE_IRQ_ENABLE_UPPER 8'h07
`define PDI_IDX_DIR_BANK_ZERO         8'h08
`define PDI_IDX_DIR_BANK_ONE          8'h09
`define PDI_IDX_DRIVE_BANK_ZERO       8'h10
`define PDI_IDX_DRIVE_BANK_ONE        8'h11
`define PDI_IDX_LEVEL_BANK_ZERO       8'h12
`define PDI_IDX_LEVEL_BANK_ONE        8'h13
`define PDI_IDX_EDGE_SEEN_FLAGS       8'h14
`define PDI_IDX_EDGE_SELECT           8'h15
`define PDI_IDX_PIN_CONTROL           8'h16

// Field layout.
`define PDI_IRQ_LINES                 4
`define PDI_BANK_ZERO_PINS            8
`define PDI_BANK_ONE_PINS             7
`define PDI_RESET_PIN_BIT             6
`define PDI_RESET_DISABLE_BIT         0

// Reset values.
`define PDI_RST_BYTE                  8'h00
`define PDI_RST_NIBBLE                4'h0

// Bus answers.
`define PDI_RESP_OKAY                 2'b00
`define PDI_RESP_SLVERR               2'b10

`endif

// File: verilog/pdi_port_direction.v
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pdi_defs.vh"

module pdi_port_direction #(
  parameter ADDR_W = 8,
  parameter NIRQ   = `PDI_IRQ_LINES,
  parameter NP0    = `PDI_BANK_ZERO_PINS,
  parameter NP1    = `PDI_BANK_ONE_PINS
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [NP0-1:0]    bank_zero_pin_i,
  output reg  [NP0-1:0]    bank_zero_pin_o,
  output reg  [NP0-1:0]    bank_zero_pin_oe,
  output reg  [NP0-1:0]    bank_zero_pullup,
  input  wire [NP1-1:0]    bank_one_pin_i,
  output reg  [NP1-1:0]    bank_one_pin_o,
  output reg  [NP1-1:0]    bank_one_pin_oe,
  output reg  [NP1-1:0]    bank_one_pullup,
  input  wire [NIRQ-1:0]   line_irq_pin,
  output reg  [NIRQ-1:0]   line_irq_request,
  output reg               pin_reset_request
);

  // Software-visible state.
  reg  [NIRQ-1:0]   line_irq_enable_bits;
  reg  [NP0-1:0]    dir_bank_zero;
  reg  [NP1-1:0]    dir_bank_one;
  reg  [NP0-1:0]    drive_bank_zero;
  reg  [NP1-1:0]    drive_bank_one;
  reg  [NIRQ-1:0]   edge_seen_flags;
  reg  [NIRQ-1:0]   edge_select;
  reg               reset_function_disable;

  // Synchronised pins and interrupt lines.
  wire [NP0-1:0]    p0_sync;
  wire [NP1-1:0]    sampled_level_bank_one;
  wire [NIRQ-1:0]   irq_sync;
  reg  [NIRQ-1:0]   irq_prev;
  reg  [1:0]        irq_warm;

  // Write channel holding registers.
  reg               aw_held;
  reg               w_held;
  reg  [ADDR_W-1:0] aw_addr;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;

  wire [ADDR_W-3:0] w_idx = aw_addr[ADDR_W-1:2];
  wire [ADDR_W-3:0] r_idx = s_axi_araddr[ADDR_W-1:2];
  wire              do_write = aw_held & w_held & ~s_axi_bvalid;
  wire              lane0 = w_strb[0];
  wire [7:0]        wbyte = w_data[7:0];

  // Address decode for the pending write.
  wire hit_en   = (w_idx == `PDI_IDX_LINE_IRQ_ENABLE_UPPER);
  wire hit_d0   = (w_idx == `PDI_IDX_DIR_BANK_ZERO);
  wire hit_d1   = (w_idx == `PDI_IDX_DIR_BANK_ONE);
  wire hit_v0   = (w_idx == `PDI_IDX_DRIVE_BANK_ZERO);
  wire hit_v1   = (w_idx == `PDI_IDX_DRIVE_BANK_ONE);
  wire hit_l0   = (w_idx == `PDI_IDX_LEVEL_BANK_ZERO);
  wire hit_l1   = (w_idx == `PDI_IDX_LEVEL_BANK_ONE);
  wire hit_fl   = (w_idx == `PDI_IDX_EDGE_SEEN_FLAGS);
  wire hit_es   = (w_idx == `PDI_IDX_EDGE_SELECT);
  wire hit_ct   = (w_idx == `PDI_IDX_PIN_CONTROL);
  wire w_mapped = hit_en | hit_d0 | hit_d1 | hit_v0 | hit_v1 | hit_l0 | hit_l1 | hit_fl | hit_es | hit_ct;
  wire wr_ok    = do_write & lane0;

  // Values the pin controls take at the next edge, so pin outputs follow writes at once.
  reg  [NP0-1:0]    next_dir_bank_zero;
  reg  [NP1-1:0]    next_dir_bank_one;
  reg  [NP0-1:0]    next_drive_bank_zero;
  reg  [NP1-1:0]    next_drive_bank_one;
  reg               next_reset_function_disable;

  always @* begin
    next_dir_bank_zero          = dir_bank_zero;
    next_dir_bank_one           = dir_bank_one;
    next_drive_bank_zero        = drive_bank_zero;
    next_drive_bank_one         = drive_bank_one;
    next_reset_function_disable = reset_function_disable;
    if (wr_ok && hit_d0) begin
      next_dir_bank_zero = wbyte[NP0-1:0];
    end
    if (wr_ok && hit_d1) begin
      next_dir_bank_one = wbyte[NP1-1:0];
    end
    if (wr_ok && hit_v0) begin
      next_drive_bank_zero = wbyte[NP0-1:0];
    end
    if (wr_ok && hit_v1) begin
      next_drive_bank_one = wbyte[NP1-1:0];
    end
    if (wr_ok && hit_ct) begin
      next_reset_function_disable = wbyte[`PDI_RESET_DISABLE_BIT];
    end
  end

  // Edge detection on the synchronised interrupt lines; select 1 means falling edge.
  wire [NIRQ-1:0] rise = irq_sync & ~irq_prev;
  wire [NIRQ-1:0] fall = ~irq_sync & irq_prev;
  wire [NIRQ-1:0] edge_hit = ((edge_select & fall) | (~edge_select & rise)) & {NIRQ{irq_warm == 2'b11}};
  wire [NIRQ-1:0] flag_clear = (wr_ok && hit_fl) ? wbyte[NIRQ-1:0] : `PDI_RST_NIBBLE;
  // A new edge wins over a clear in the same cycle.
  wire [NIRQ-1:0] next_flags = (edge_seen_flags & ~flag_clear) | edge_hit;

  // Pins and interrupt lines cross into the clock domain through two flip-flops.
  pdi_sync2 #(.W(NP0), .RST_BIT(1'b0)) pdi_sync2_bank_zero_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (bank_zero_pin_i),
    .q       (p0_sync)
  );

  // Bank one resets high so the reset-input pin does not look low right after reset.
  pdi_sync2 #(.W(NP1), .RST_BIT(1'b1)) pdi_sync2_bank_one_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (bank_one_pin_i),
    .q       (sampled_level_bank_one)
  );

  pdi_sync2 #(.W(NIRQ), .RST_BIT(1'b0)) pdi_sync2_irq_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (line_irq_pin),
    .q       (irq_sync)
  );

  // Edges are ignored until the synchronisers hold real levels, so an idle-high line raises no flag.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev <= `PDI_RST_NIBBLE;
      irq_warm <= 2'b00;
    end else begin
      irq_prev <= irq_sync;
      if (irq_warm != 2'b11) begin
        irq_warm <= irq_warm + 2'b01;
      end
    end
  end

  // Interrupt enable register.
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_irq_enable_bits <= `PDI_RST_NIBBLE;
    end else if (wr_ok && hit_en) begin
      line_irq_enable_bits <= wbyte[NIRQ-1:0];
    end
  end

  // Edge select register.
  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_select <= `PDI_RST_NIBBLE;
    end else if (wr_ok && hit_es) begin
      edge_select <= wbyte[NIRQ-1:0];
    end
  end

  // Direction, drive-value and reset-disable registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_bank_zero          <= `PDI_RST_BYTE;
      dir_bank_one           <= {NP1{1'b0}};
      drive_bank_zero        <= `PDI_RST_BYTE;
      drive_bank_one         <= {NP1{1'b0}};
      reset_function_disable <= 1'b0;
    end else begin
      dir_bank_zero          <= next_dir_bank_zero;
      dir_bank_one           <= next_dir_bank_one;
      drive_bank_zero        <= next_drive_bank_zero;
      drive_bank_one         <= next_drive_bank_one;
      reset_function_disable <= next_reset_function_disable;
    end
  end

  // Edge flags.
  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_seen_flags <= `PDI_RST_NIBBLE;
    end else begin
      edge_seen_flags <= next_flags;
    end
  end

  // Bank zero pin drive.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bank_zero_pin_o  <= `PDI_RST_BYTE;
      bank_zero_pin_oe <= `PDI_RST_BYTE;
      bank_zero_pullup <= `PDI_RST_BYTE;
    end else begin
      bank_zero_pin_o  <= next_drive_bank_zero & next_dir_bank_zero;
      bank_zero_pin_oe <= next_dir_bank_zero;
      bank_zero_pullup <= ~next_dir_bank_zero & next_drive_bank_zero;
    end
  end

  // Bank one pin drive.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bank_one_pin_o  <= {NP1{1'b0}};
      bank_one_pin_oe <= {NP1{1'b0}};
      bank_one_pullup <= {NP1{1'b0}};
    end else begin
      bank_one_pin_o  <= next_drive_bank_one & next_dir_bank_one;
      bank_one_pin_oe <= next_dir_bank_one;
      bank_one_pullup <= ~next_dir_bank_one & next_drive_bank_one;
    end
  end

  // Interrupt and reset requests.
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_irq_request  <= `PDI_RST_NIBBLE;
      pin_reset_request <= 1'b0;
    end else begin
      line_irq_request  <= edge_seen_flags & line_irq_enable_bits;
      // The pin level comes from the wire, so a low the port drives itself also resets.
      pin_reset_request <= ~reset_function_disable & ~sampled_level_bank_one[`PDI_RESET_PIN_BIT];
    end
  end

  // Write channel: address and data are taken in either order, answered once both are in.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PDI_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? `PDI_RESP_OKAY : `PDI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data; reserved bits come back as zero.
  reg [31:0] rd_word;
  reg        rd_mapped;

  always @* begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (r_idx)
      `PDI_IDX_LINE_IRQ_ENABLE_UPPER: rd_word[NIRQ-1:0] = line_irq_enable_bits;
      `PDI_IDX_DIR_BANK_ZERO:         rd_word[NP0-1:0]  = dir_bank_zero;
      `PDI_IDX_DIR_BANK_ONE:          rd_word[NP1-1:0]  = dir_bank_one;
      `PDI_IDX_DRIVE_BANK_ZERO:       rd_word[NP0-1:0]  = drive_bank_zero;
      `PDI_IDX_DRIVE_BANK_ONE:        rd_word[NP1-1:0]  = drive_bank_one;
      `PDI_IDX_LEVEL_BANK_ZERO:       rd_word[NP0-1:0]  = p0_sync;
      `PDI_IDX_LEVEL_BANK_ONE:        rd_word[NP1-1:0]  = sampled_level_bank_one;
      `PDI_IDX_EDGE_SEEN_FLAGS:       rd_word[NIRQ-1:0] = edge_seen_flags;
      `PDI_IDX_EDGE_SELECT:           rd_word[NIRQ-1:0] = edge_select;
      `PDI_IDX_PIN_CONTROL:           rd_word[`PDI_RESET_DISABLE_BIT] = reset_function_disable;
      default:                        rd_mapped = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PDI_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_mapped ? `PDI_RESP_OKAY : `PDI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // pdi_port_direction

// Two-stage synchroniser for signals from outside the clock domain.
module pdi_sync2 #(
  parameter       W       = 1,
  parameter [0:0] RST_BIT = 1'b0
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {W{RST_BIT}};
      q    <= {W{RST_BIT}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // pdi_sync2

// File: sim/pdi_pin_model.sv
`timescale 1ns/1ps
module pdi_pin_model #(
  parameter N = 8
) (
  input  wire         clk,
  input  wire [N-1:0] oe,
  input  wire [N-1:0] o,
  input  wire [N-1:0] pull_en,
  input  wire [N-1:0] ext_en,
  input  wire [N-1:0] ext_val,
  output wire [N-1:0] pin
);
  // A pin that nobody drives and nothing pulls floats; the changing pattern keeps it from looking settled.
  logic [N-1:0] flt = '0;
  always @(posedge clk) flt <= ~flt;
  assign pin = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull_en | flt));
endmodule // pdi_pin_model

// File: sim/pdi_port_direction_asserts.sv
`timescale 1ns/1ps
module pdi_port_direction_asserts #(
  parameter ADDR_W = 8,
  parameter NIRQ   = 4,
  parameter NP0    = 8,
  parameter NP1    = 7
) (
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire              s_axi_bvalid,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire              s_axi_rvalid,
  input wire [NP0-1:0]    bank_zero_pin_oe,
  input wire [NP0-1:0]    bank_zero_pullup,
  input wire [NP1-1:0]    bank_one_pin_i,
  input wire [NP1-1:0]    bank_one_pin_o,
  input wire [NP1-1:0]    bank_one_pin_oe,
  input wire [NIRQ-1:0]   line_irq_request,
  input wire              pin_reset_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0]       wd;
  logic [ADDR_W-1:0] ra;
  wire               both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Remember the last accepted write data and read address for the later checks.
  always @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  reset_clear_a: assert property ($rose(aresetn) |-> !bank_zero_pin_oe && !bank_one_pin_oe && !line_irq_request)
    else $error("outputs not clear after reset");
  drive_gate_a: assert property ((bank_one_pin_o & ~bank_one_pin_oe) == '0)
    else $error("pin value without output enable");
  pull_gate_a: assert property ((bank_zero_pullup & bank_zero_pin_oe) == '0)
    else $error("pullup on while pin driven");
  dir_zero_a: assert property (both && s_axi_awaddr[7:2] == 6'h08 |-> ##2 bank_zero_pin_oe == wd[NP0-1:0])
    else $error("bank zero enables differ from written direction");
  dir_one_a: assert property (both && s_axi_awaddr[7:2] == 6'h09 |-> ##2 bank_one_pin_oe == wd[NP1-1:0])
    else $error("bank one enables differ from written direction");
  write_resp_a: assert property (both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not one cycle after the write");
  rsv_bits_a: assert property (s_axi_rvalid && ra[7:2] == 6'h09 |-> s_axi_rdata[31:7] == '0)
    else $error("reserved direction bits read nonzero");
  pin_high_a: assert property (bank_one_pin_i[6] [*4] |-> !pin_reset_request)
    else $error("reset request while pin high");
  cover property (both);
  cover property (s_axi_rvalid);
  cover property (pin_reset_request);
endmodule // pdi_port_direction_asserts

bind pdi_port_direction pdi_port_direction_asserts #(.ADDR_W(ADDR_W), .NIRQ(NIRQ), .NP0(NP0), .NP1(NP1))
  pdi_port_direction_asserts_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .bank_zero_pin_oe, .bank_zero_pullup, .bank_one_pin_i, .bank_one_pin_o, .bank_one_pin_oe,
  .line_irq_request, .pin_reset_request);

// File: sim/pdi_port_direction_bench.sv
`timescale 1ns/1ps
`include "pdi_defs.vh"
module pdi_port_direction_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb, line_irq_pin;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_reset_request;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  bank_zero_pin_i, bank_zero_pin_o, bank_zero_pin_oe, bank_zero_pullup;
  wire  [6:0]  bank_one_pin_i, bank_one_pin_o, bank_one_pin_oe, bank_one_pullup;
  wire  [3:0]  line_irq_request;
  logic [7:0]  ext_en_zero, ext_val_zero;
  logic [6:0]  ext_en_one, ext_val_one;
  integer      n_errors, check_count;

  pdi_port_direction pdi_port_direction_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bank_zero_pin_i, .bank_zero_pin_o, .bank_zero_pin_oe,
    .bank_zero_pullup, .bank_one_pin_i, .bank_one_pin_o, .bank_one_pin_oe, .bank_one_pullup, .line_irq_pin,
    .line_irq_request, .pin_reset_request);
  pdi_pin_model #(.N(8)) pdi_pin_model_i (.clk(aclk), .oe(bank_zero_pin_oe), .o(bank_zero_pin_o),
    .pull_en(bank_zero_pullup), .ext_en(ext_en_zero), .ext_val(ext_val_zero), .pin(bank_zero_pin_i));
  pdi_pin_model #(.N(7)) pdi_pin_model_one_i (.clk(aclk), .oe(bank_one_pin_oe), .o(bank_one_pin_o),
    .pull_en(bank_one_pullup), .ext_en(ext_en_one), .ext_val(ext_val_one), .pin(bank_one_pin_i));

  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, resp);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, resp);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    give_verdict;
  end
  initial begin
    aclk = 1'b0;
    n_errors = 0;
    check_count = 0;
    aresetn <= 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, line_irq_pin} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    s_axi_wstrb <= 4'hf;
    ext_en_zero <= 8'hff;
    ext_val_zero <= 8'h0f;
    ext_en_one <= 7'h40;
    ext_val_one <= 7'h40;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h1c, 32'h0000_0000, `PDI_RESP_OKAY);
    rd(8'h20, 32'h0000_0000, `PDI_RESP_OKAY);
    rd(8'h24, 32'h0000_0000, `PDI_RESP_OKAY);
    wr(8'h24, 32'h0000_00ff, `PDI_RESP_OKAY);
    rd(8'h24, 32'h0000_007f, `PDI_RESP_OKAY);
    chk(bank_one_pin_oe, 32'h0000_007f);
    chk(bank_one_pin_o, 32'h0000_0000);
    idle(6);
    chk(pin_reset_request, 32'h0000_0001);
    wr(8'h58, 32'h0000_0001, `PDI_RESP_OKAY);
    idle(4);
    chk(pin_reset_request, 32'h0000_0000);
    wr(8'h20, 32'h0000_00a5, `PDI_RESP_OKAY);
    wr(8'h40, 32'h0000_003c, `PDI_RESP_OKAY);
    chk(bank_zero_pin_oe, 32'h0000_00a5);
    chk(bank_zero_pin_o, 32'h0000_0024);
    chk(bank_zero_pullup, 32'h0000_0018);
    rd(8'h48, 32'h0000_002e, `PDI_RESP_OKAY);
    @(posedge aclk);
    line_irq_pin <= 4'h1;
    idle(8);
    chk(line_irq_request, 32'h0000_0000);
    wr(8'h1c, 32'h0000_00ff, `PDI_RESP_OKAY);
    rd(8'h1c, 32'h0000_000f, `PDI_RESP_OKAY);
    chk(line_irq_request, 32'h0000_0001);
    wr(8'h50, 32'h0000_000f, `PDI_RESP_OKAY);
    idle(2);
    chk(line_irq_request, 32'h0000_0000);
    wr(8'hfc, 32'h0000_0001, `PDI_RESP_SLVERR);
    rd(8'hfc, 32'h0000_0000, `PDI_RESP_SLVERR);
    give_verdict;
  end
endmodule // pdi_port_direction_bench
